// file: inc/srpc_defines.svh
// Command codes, property identifiers, defaults and key codes of the reader.
`ifndef SRPC_DEFINES_SVH
`define SRPC_DEFINES_SVH
`define SRPC_CMD_GET    8'h00
`define SRPC_CMD_SET    8'h01
`define SRPC_LEN_GET    8'h01
`define SRPC_LEN_SET    8'h02
`define SRPC_PRP_CONV   8'h0f
`define SRPC_PRP_IFACE  8'h10
`define SRPC_RES_OK     8'h00
`define SRPC_RES_ERR    8'h01
`define SRPC_CONV_MAP   1'b0
`define SRPC_CONV_ALT   1'b1
`define SRPC_CONV_DEF   1'b0
`define SRPC_IFACE_DEF  1'b1
`define SRPC_MOD_NONE   8'h00
`define SRPC_MOD_LSHIFT 8'h02
`define SRPC_MOD_LALT   8'h04
`define SRPC_KEY_NONE   8'h00
`define SRPC_KEY_A      8'h04
`define SRPC_KEY_1      8'h1e
`define SRPC_KEY_0      8'h27
`define SRPC_KEY_ENTER  8'h28
`define SRPC_KEY_SPACE  8'h2c
`define SRPC_KEY_SLASH  8'h38
`define SRPC_KEY_KP1    8'h59
`define SRPC_KEY_KP0    8'h62
`endif

// file: inc/srpc_pkg.sv
// Types shared by the property handler and keystroke encoder.
`default_nettype none
package srpc_pkg;
  typedef struct packed {
    logic [7:0] code;
    logic [7:0] mods;
  } srpc_key_t;
  typedef enum logic [2:0] {
    PS_CMD  = 3'b000,
    PS_LEN  = 3'b001,
    PS_DATA = 3'b010,
    PS_EXEC = 3'b011,
    PS_RSP  = 3'b100
  } srpc_pstate_t;
  typedef enum logic [0:0] {
    ES_IDLE = 1'b0,
    ES_SEND = 1'b1
  } srpc_estate_t;
endpackage : srpc_pkg
`default_nettype wire

// file: rtl/srpc_top.sv
// What this block does
// (RULE_01) Keystroke conversion property, id 0x0f, one byte, get and set.
// (RULE_02) Conversion value 0 is US keymap, 1 is ALT decimal; default 0.
// (RULE_03) Keymap mode sends the table key with its stored modifier.
// (RULE_04) ALT mode: keypad decimal digits, most significant first, left ALT.
// (RULE_05) Values kept in nonvolatile storage; changes act after power cycle.
// (RULE_06) Interface selection property, id 0x10, one byte, default 1.
// (RULE_07) Interface value 0 means HID reader, 1 means keyboard emulation.
// (RULE_08) Host should change interface first, then power cycle.
// (RULE_09) Set is 01 02 id value; success answers 00 00.
// (RULE_10) Get is 00 01 id.
// (RULE_11) Successful get answers 00 01 value.
// (RULE_12) Every length byte counts the bytes that follow it.
`timescale 1ns/100ps
`default_nettype none
`include "srpc_defines.svh"
module srpc_top
  import srpc_pkg::*;
(
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       cmd_valid_i,
  input  wire logic [7:0] cmd_data_i,
  output logic            cmd_ready_o,
  output logic            rsp_valid_o,
  output logic [7:0]      rsp_data_o,
  output logic            rsp_last_o,
  input  wire logic       rsp_ready_i,
  input  wire logic       nv_conv_i,
  input  wire logic       nv_iface_i,
  output logic            nv_we_o,
  output logic [7:0]      nv_prop_o,
  output logic            nv_value_o,
  output logic            hid_mode_o,
  input  wire logic       chr_valid_i,
  input  wire logic [7:0] chr_data_i,
  output logic            chr_ready_o,
  output logic            key_valid_o,
  output srpc_key_t       key_o,
  input  wire logic       key_ready_i
);
  srpc_pstate_t ps_r, ps_nxt;
  srpc_estate_t es_r;
  logic [7:0] cmd_r, len_r, cnt_r, id_r, val_r;
  logic [7:0] rbuf_r [0:2];
  logic [1:0] rn_r, ridx_r;
  logic       load_r, conv_st_r, iface_st_r, conv_act_r;
  logic [7:0] dig_r [0:2];
  logic [1:0] dcnt_r;
  // Command path.
  wire cmd_hs  = cmd_valid_i && cmd_ready_o;
  wire rsp_hs  = rsp_valid_o && rsp_ready_i;
  wire last_in = (cnt_r + 8'h01) == len_r;
  wire id_ok   = (id_r == `SRPC_PRP_CONV) || (id_r == `SRPC_PRP_IFACE); // RULE_01 RULE_06
  wire ok_get  = cmd_r == `SRPC_CMD_GET && len_r == `SRPC_LEN_GET && id_ok; // RULE_10
  wire ok_set  = cmd_r == `SRPC_CMD_SET && len_r == `SRPC_LEN_SET && id_ok
                 && val_r[7:1] == 7'h00; // RULE_09
  wire get_val = (id_r == `SRPC_PRP_CONV) ? conv_st_r : iface_st_r;
  always_comb begin
    ps_nxt = ps_r;
    unique case (ps_r)
      PS_CMD:  if (cmd_hs) ps_nxt = PS_LEN;
      PS_LEN:  if (cmd_hs) ps_nxt = (cmd_data_i == 8'h00) ? PS_EXEC : PS_DATA; // RULE_12
      PS_DATA: if (cmd_hs && last_in) ps_nxt = PS_EXEC; // RULE_12
      PS_EXEC: ps_nxt = PS_RSP;
      PS_RSP:  if (rsp_hs && rsp_last_o) ps_nxt = PS_CMD;
      default: ps_nxt = PS_CMD;
    endcase
  end
  wire ready_nxt = (ps_nxt == PS_CMD) || (ps_nxt == PS_LEN) || (ps_nxt == PS_DATA);
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ps_r        <= PS_CMD;
      cmd_ready_o <= 1'b0;
      cmd_r       <= 8'h00;
      len_r       <= 8'h00;
      cnt_r       <= 8'h00;
      id_r        <= 8'h00;
      val_r       <= 8'h00;
    end else begin
      ps_r        <= ps_nxt;
      cmd_ready_o <= ready_nxt;
      if (cmd_hs && ps_r == PS_CMD) cmd_r <= cmd_data_i;
      if (cmd_hs && ps_r == PS_LEN) begin
        len_r <= cmd_data_i;
        cnt_r <= 8'h00;
      end
      if (cmd_hs && ps_r == PS_DATA) begin
        cnt_r <= cnt_r + 8'h01;
        if (cnt_r == 8'h00) id_r <= cmd_data_i;
        if (cnt_r == 8'h01) val_r <= cmd_data_i;
      end
    end
  end
  // Answer path: result code, length, then any data.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rsp_valid_o <= 1'b0;
      rsp_data_o  <= 8'h00;
      rsp_last_o  <= 1'b0;
      rn_r        <= 2'd0;
      ridx_r      <= 2'd0;
      rbuf_r[0]   <= 8'h00;
      rbuf_r[1]   <= 8'h00;
      rbuf_r[2]   <= 8'h00;
    end else if (ps_r == PS_EXEC) begin
      rsp_valid_o <= 1'b1;
      rsp_data_o  <= (ok_get || ok_set) ? `SRPC_RES_OK : `SRPC_RES_ERR; // RULE_09 RULE_11
      rsp_last_o  <= 1'b0;
      ridx_r      <= 2'd0;
      rn_r        <= ok_get ? 2'd3 : 2'd2;
      rbuf_r[1]   <= ok_get ? `SRPC_LEN_GET : 8'h00; // RULE_11 RULE_12
      rbuf_r[2]   <= {7'h00, get_val}; // RULE_11
    end else if (rsp_hs) begin
      if (rsp_last_o) begin
        rsp_valid_o <= 1'b0;
        rsp_last_o  <= 1'b0;
      end else begin
        ridx_r     <= ridx_r + 2'd1;
        rsp_data_o <= rbuf_r[ridx_r + 2'd1];
        rsp_last_o <= (ridx_r + 2'd2) == rn_r;
      end
    end
  end
  // Stored values follow writes at once; the active copy only at power-up.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      load_r     <= 1'b1;
      conv_st_r  <= `SRPC_CONV_DEF; // RULE_02
      iface_st_r <= `SRPC_IFACE_DEF; // RULE_06
      conv_act_r <= `SRPC_CONV_DEF;
      hid_mode_o <= ~`SRPC_IFACE_DEF;
      nv_we_o    <= 1'b0;
      nv_prop_o  <= 8'h00;
      nv_value_o <= 1'b0;
    end else begin
      load_r  <= 1'b0;
      nv_we_o <= 1'b0;
      if (load_r) begin
        conv_st_r  <= nv_conv_i; // RULE_05
        iface_st_r <= nv_iface_i;
        conv_act_r <= nv_conv_i; // RULE_05
        hid_mode_o <= ~nv_iface_i; // RULE_07
      end else if (ps_r == PS_EXEC && ok_set) begin
        nv_we_o    <= 1'b1; // RULE_05
        nv_prop_o  <= id_r;
        nv_value_o <= val_r[0];
        if (id_r == `SRPC_PRP_CONV) conv_st_r <= val_r[0];
        else iface_st_r <= val_r[0];
      end
    end
  end
  // Keystroke encoder.
  function automatic srpc_key_t us_map(input logic [7:0] c);
    srpc_key_t k;
    k = '{code: `SRPC_KEY_NONE, mods: `SRPC_MOD_NONE};
    if (c >= 8'h61 && c <= 8'h7a) k.code = c - 8'h61 + `SRPC_KEY_A;
    else if (c >= 8'h41 && c <= 8'h5a) begin
      k.code = c - 8'h41 + `SRPC_KEY_A;
      k.mods = `SRPC_MOD_LSHIFT;
    end else if (c >= 8'h31 && c <= 8'h39) k.code = c - 8'h31 + `SRPC_KEY_1;
    else begin
      unique case (c)
        8'h30:   k.code = `SRPC_KEY_0;
        8'h0d:   k.code = `SRPC_KEY_ENTER;
        8'h20:   k.code = `SRPC_KEY_SPACE;
        8'h2f:   k.code = `SRPC_KEY_SLASH;
        8'h3f:   k = '{code: `SRPC_KEY_SLASH, mods: `SRPC_MOD_LSHIFT};
        8'h2d:   k.code = 8'h2d;
        8'h3d:   k.code = 8'h2e;
        8'h3b:   k.code = 8'h33;
        8'h3a:   k = '{code: 8'h33, mods: `SRPC_MOD_LSHIFT};
        8'h2c:   k.code = 8'h36;
        8'h2e:   k.code = 8'h37;
        8'h5f:   k = '{code: 8'h2d, mods: `SRPC_MOD_LSHIFT};
        8'h25:   k = '{code: 8'h22, mods: `SRPC_MOD_LSHIFT};
        8'h5e:   k = '{code: 8'h23, mods: `SRPC_MOD_LSHIFT};
        default: k.code = `SRPC_KEY_NONE;
      endcase
    end
    return k;
  endfunction : us_map
  function automatic logic [7:0] kp_key(input logic [7:0] d);
    return (d == 8'h00) ? `SRPC_KEY_KP0 : d - 8'h01 + `SRPC_KEY_KP1;
  endfunction : kp_key
  wire       chr_hs = chr_valid_i && chr_ready_o;
  wire [7:0] hund   = (chr_data_i >= 8'd200) ? 8'd2 : (chr_data_i >= 8'd100) ? 8'd1 : 8'd0;
  wire [7:0] rem2   = chr_data_i - 8'((hund * 8'd100));
  wire [7:0] tens   = 8'(rem2 / 8'd10);
  wire [7:0] ones   = rem2 - 8'(tens * 8'd10);
  wire       key_hs = key_valid_o && key_ready_i;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      es_r        <= ES_IDLE;
      chr_ready_o <= 1'b0;
      key_valid_o <= 1'b0;
      key_o       <= '{code: `SRPC_KEY_NONE, mods: `SRPC_MOD_NONE};
      dcnt_r      <= 2'd0;
      dig_r[0]    <= 8'h00;
      dig_r[1]    <= 8'h00;
      dig_r[2]    <= 8'h00;
    end else if (es_r == ES_IDLE) begin
      chr_ready_o <= !load_r && !chr_hs;
      if (chr_hs) begin
        es_r        <= ES_SEND;
        key_valid_o <= 1'b1;
        if (conv_act_r == `SRPC_CONV_MAP) begin
          key_o  <= us_map(chr_data_i); // RULE_03
          dcnt_r <= 2'd0;
        end else begin
          key_o    <= '{code: kp_key(hund), mods: `SRPC_MOD_LALT}; // RULE_04
          dig_r[1] <= tens;
          dig_r[2] <= ones;
          dcnt_r   <= 2'd2;
        end
      end
    end else if (key_hs) begin
      if (dcnt_r == 2'd0) begin
        key_valid_o <= 1'b0;
        es_r        <= ES_IDLE;
        chr_ready_o <= 1'b1;
      end else begin
        key_o  <= '{code: kp_key(dig_r[2'd3 - dcnt_r]),
                   mods: `SRPC_MOD_LALT}; // RULE_04
        dcnt_r <= dcnt_r - 2'd1;
      end
    end
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_set_ok_code: assert property (ps_r == PS_EXEC && ok_set |=> rsp_valid_o && rsp_data_o == `SRPC_RES_OK) else $error("set not answered ok"); // RULE_09
  a_get_len_one: assert property (rsp_valid_o && ridx_r == 2'd1 && rn_r == 2'd3 |-> rsp_data_o == `SRPC_LEN_GET) else $error("get length wrong"); // RULE_11
  a_len_counts: assert property (rsp_valid_o && ridx_r == 2'd1 |-> rsp_data_o == 8'(rn_r - 2'd2) && rsp_last_o == (rn_r == 2'd2)) else $error("length mismatch"); // RULE_12
  a_nv_write: assert property (ps_r == PS_EXEC && ok_set |=> nv_we_o && nv_prop_o == $past(id_r)) else $error("no storage write"); // RULE_05
  a_active_hold: assert property (!load_r |=> $stable(conv_act_r) && $stable(hid_mode_o)) else $error("active mode changed"); // RULE_05
  a_alt_mod: assert property (key_valid_o && conv_act_r == `SRPC_CONV_ALT |-> key_o.mods == `SRPC_MOD_LALT) else $error("alt modifier missing"); // RULE_04
  a_qmark_map: assert property (chr_hs && conv_act_r == `SRPC_CONV_MAP && chr_data_i == 8'h3f |=> key_o.code == `SRPC_KEY_SLASH && key_o.mods == `SRPC_MOD_LSHIFT) else $error("question mark mapped wrong"); // RULE_03
  a_alt_first: assert property (chr_hs && conv_act_r == `SRPC_CONV_ALT && chr_data_i == 8'h3f |=> key_o.code == `SRPC_KEY_KP0) else $error("alt digit order wrong"); // RULE_04
  a_hid_follows: assert property (!$past(rst_i) && $past(load_r) // RULE_07
    |-> hid_mode_o == !$past(nv_iface_i))
    else $error("interface mode not taken");
endmodule : srpc_top
`default_nettype wire

// file: dv/srpc_host_model.sv
// Host side model that takes answer bytes and key reports with random stalls.
`timescale 1ns/100ps
`default_nettype none
module srpc_host_model #(
  parameter int SEED = 29860
) (
  input  wire logic clk_i,
  output logic      rsp_ready_o,
  output logic      key_ready_o
);
  integer seed = SEED;
  initial begin
    rsp_ready_o = 1'b0;
    key_ready_o = 1'b0;
  end
  // Ready drops at random, about one cycle in four, so some answer bytes and reports must wait.
  always @(posedge clk_i) begin
    #1;
    rsp_ready_o = ($random(seed) & 3) != 0;
    key_ready_o = ($random(seed) & 3) != 0;
  end
endmodule : srpc_host_model
`default_nettype wire

// file: dv/tb.sv
// Self-checking bench of the property handler and keystroke encoder.
`timescale 1ns/100ps
`default_nettype none
`include "srpc_defines.svh"
`define CHK(nm, e, s) begin cmp_count++; if ((s) !== (e)) begin fails++; \
  $display("wrong value %s expected %h seen %h", nm, e, s); end end
module tb;
  logic                 clk_i = 1'b0, rst_i = 1'b1;
  logic                 cmd_valid_i = 1'b0, chr_valid_i = 1'b0;
  logic [7:0]           cmd_data_i = 8'h00, chr_data_i = 8'h00;
  logic                 nv_conv_i = 1'b0, nv_iface_i = 1'b1;
  logic                 cmd_ready_o, rsp_valid_o, rsp_last_o, rsp_ready_i;
  logic                 nv_we_o, nv_value_o, hid_mode_o, chr_ready_o;
  logic                 key_valid_o, key_ready_i;
  logic [7:0]           rsp_data_o, nv_prop_o;
  srpc_pkg::srpc_key_t  key_o;
  logic [8:0]           rq[$], nq[$];
  logic [15:0]          kq[$];
  integer               seed = 29860;
  int                   fails = 0, cmp_count = 0;
  srpc_top uut (.clk_i(clk_i), .rst_i(rst_i), .cmd_valid_i(cmd_valid_i),
    .cmd_data_i(cmd_data_i), .cmd_ready_o(cmd_ready_o),
    .rsp_valid_o(rsp_valid_o), .rsp_data_o(rsp_data_o),
    .rsp_last_o(rsp_last_o), .rsp_ready_i(rsp_ready_i),
    .nv_conv_i(nv_conv_i), .nv_iface_i(nv_iface_i), .nv_we_o(nv_we_o),
    .nv_prop_o(nv_prop_o), .nv_value_o(nv_value_o),
    .hid_mode_o(hid_mode_o), .chr_valid_i(chr_valid_i),
    .chr_data_i(chr_data_i), .chr_ready_o(chr_ready_o),
    .key_valid_o(key_valid_o), .key_o(key_o), .key_ready_i(key_ready_i));
  srpc_host_model host (.clk_i(clk_i), .rsp_ready_o(rsp_ready_i),
    .key_ready_o(key_ready_i));
  always #20 clk_i = ~clk_i;
  task automatic print_verdict();
    `CHK("pending", 0, rq.size() + kq.size() + nq.size())
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : print_verdict
  // Outputs are settled at the falling edge; a transfer seen there is taken
  // at the next rising edge.
  always @(negedge clk_i) begin : watch
    logic [8:0]  r;
    logic [15:0] k;
    if (rsp_valid_o === 1'b1 && rsp_ready_i) begin
      r = rq.size() ? rq.pop_front() : 9'bx;
      `CHK("answer", r, {rsp_data_o, rsp_last_o})
      `CHK("busy", 1'b0, cmd_ready_o)
    end
    if (key_valid_o === 1'b1 && key_ready_i) begin
      k = kq.size() ? kq.pop_front() : 16'bx;
      `CHK("key", k, key_o)
      `CHK("chr busy", 1'b0, chr_ready_o)
    end
    if (nv_we_o === 1'b1) begin
      r = nq.size() ? nq.pop_front() : 9'bx;
      `CHK("store", r, {nv_prop_o, nv_value_o})
      if (nv_prop_o == `SRPC_PRP_CONV) nv_conv_i = nv_value_o;
      else nv_iface_i = nv_value_o;
    end
  end
  task automatic hs(input bit is_chr);
    logic ok;
    do begin
      @(negedge clk_i);
      ok = is_chr ? chr_ready_o : cmd_ready_o;
      @(posedge clk_i);
    end while (ok !== 1'b1);
    #1;
  endtask : hs
  task automatic idle();
    do @(posedge clk_i); while (rq.size() || kq.size());
    #1;
  endtask : idle
  task automatic req(input logic [31:0] b, input int n);
    for (int i = n - 1; i >= 0; i--) begin
      cmd_valid_i = 1'b1;
      cmd_data_i  = b[8*i +: 8];
      hs(1'b0);
    end
    cmd_valid_i = 1'b0;
    idle();
  endtask : req
  task automatic get(input logic [7:0] id, input logic [7:0] v);
    rq.push_back({`SRPC_RES_OK, 1'b0});
    rq.push_back({`SRPC_LEN_GET, 1'b0});
    rq.push_back({v, 1'b1});
    req({8'h00, `SRPC_CMD_GET, `SRPC_LEN_GET, id}, 3);
  endtask : get
  task automatic set(input logic [7:0] id, v, input logic ok);
    rq.push_back({ok ? `SRPC_RES_OK : `SRPC_RES_ERR, 1'b0});
    rq.push_back({8'h00, 1'b1});
    if (ok) nq.push_back({id, v[0]});
    req({`SRPC_CMD_SET, `SRPC_LEN_SET, id, v}, 4);
  endtask : set
  task automatic chr(input logic [7:0] c, input logic alt);
    if (!alt) kq.push_back({`SRPC_KEY_SLASH, `SRPC_MOD_LSHIFT});
    else for (int d = 100; d > 0; d /= 10)
      kq.push_back({(c / d) % 10 == 0 ? `SRPC_KEY_KP0
        : `SRPC_KEY_KP1 + 8'((c / d) % 10 - 1), `SRPC_MOD_LALT});
    chr_valid_i = 1'b1;
    chr_data_i  = c;
    hs(1'b1);
    chr_valid_i = 1'b0;
    idle();
  endtask : chr
  task automatic power_up();
    @(posedge clk_i) #1 rst_i = 1'b1;
    repeat (4) @(posedge clk_i);
    #1 rst_i = 1'b0;
    repeat (2) @(posedge clk_i);
    #1;
  endtask : power_up
  initial begin
    power_up();
    `CHK("hid", 1'b0, hid_mode_o)
    get(`SRPC_PRP_CONV, 8'h00);
    get(`SRPC_PRP_IFACE, 8'h01);
    chr(8'h3f, 1'b0);
    set(`SRPC_PRP_IFACE, 8'h00, 1'b1);
    get(`SRPC_PRP_IFACE, 8'h00);
    set(`SRPC_PRP_CONV, 8'h02, 1'b0);
    set(8'h0e, 8'h01, 1'b0);
    rq.push_back({`SRPC_RES_ERR, 1'b0});
    rq.push_back({8'h00, 1'b1});
    req({16'h0000, 8'h05, 8'h00}, 2);
    set(`SRPC_PRP_CONV, 8'h01, 1'b1);
    chr(8'h3f, 1'b0);
    `CHK("hid", 1'b0, hid_mode_o)
    power_up();
    `CHK("hid", 1'b1, hid_mode_o)
    get(`SRPC_PRP_CONV, 8'h01);
    chr(8'h3f, 1'b1);
    repeat (8) chr(8'($random(seed)) & 8'h7f, 1'b1);
    print_verdict();
  end
  initial begin
    #400000;
    fails++;
    print_verdict();
  end
endmodule : tb
`default_nettype wire
